// ### shared/asa_map.vh
// Register map, codes and timing constants of the alarm aggregator
`ifndef ASA_MAP_VH
`define ASA_MAP_VH
`define ASA_CLK_HZ 50000000
`define ASA_MS_CYC (`ASA_CLK_HZ / 1000)
`define ASA_DWELL_MS 1000
`define ASA_WD_MS_RST 16'h03e8
`define ASA_STUCK_PCT 7'h4d
// Byte offsets
`define ASA_OFF_CTRL 4'h0
`define ASA_OFF_WDTO 4'h4
`define ASA_OFF_STAT 4'h8
`define ASA_OFF_DISP 4'hc
// Control fields
`define ASA_CTRL_W 8
`define ASA_CTRL_RST 8'h00
`define ASA_F_VAR_LO 0
`define ASA_F_VAR_HI 1
`define ASA_F_SEL_OPEN 2
`define ASA_F_SEL_ILIM 3
`define ASA_F_SEL_STUCK 4
`define ASA_F_SEL_WD 5
`define ASA_F_WD_EN 6
`define ASA_F_CL_FIT 7
// Product variants
`define ASA_VAR_FIRST 2'h0
`define ASA_VAR_SECOND 2'h1
`define ASA_VAR_THIRD 2'h2
// Alarm index order is the display priority, highest first
`define ASA_N_ALM 12
`define ASA_A_OVHEAT 0
`define ASA_A_PHASE 1
`define ASA_A_WDOG 2
`define ASA_A_STUCK 3
`define ASA_A_ILIM 4
`define ASA_A_OPEN 5
`define ASA_A_UNBAL 6
`define ASA_A_CARD 7
`define ASA_A_LINE 8
`define ASA_A_AUXHI 9
`define ASA_A_AUXLO 10
`define ASA_A_DRY 11
`define ASA_MSG_HOME 4'h0
`define ASA_RESP_OK 2'h0
`define ASA_RESP_ERR 2'h2
`endif

// ### hw/asa_alarm_aggregator.v
// Alarm and message aggregator with AXI4-Lite register access
`timescale 1ns/1ps
`include "asa_map.vh"
module asa_alarm_aggregator #(
  parameter DWELL_CYC = `ASA_DWELL_MS * `ASA_MS_CYC,
  parameter MS_CYC = `ASA_MS_CYC
) (
  input wire sys_clk, // 50 MHz clock
  input wire srst, // Synchronous reset, high
  input wire clk_en, // Freezes all state while low
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire elec_powered, // Electronics have supply
  input wire aux_over, // Aux supply above maximum
  input wire aux_under, // Aux supply below minimum
  input wire line_absent, // Line power missing
  input wire drying_active, // Heater drying controls output
  input wire load_open, // Load resistance above expected
  input wire cur_override, // Current loop overrides demand
  input wire [2:0] phase_lost, // Per-phase line loss
  input wire card_fault, // Memory card malfunction
  input wire switch_on_cont, // Power switch on continuously
  input wire overheat, // Heat sink above threshold
  input wire [2:0] leg_unbal, // Per-leg balance fault
  input wire comm_rx, // Serial or USB reception pulse
  input wire [6:0] set_point, // Demand set point in percent
  output reg [3:0] disp_msg, // Message code, 0 home page
  output reg disp_flash, // Upper line flashes
  output reg [1:0] disp_leg, // Unbalanced leg 1..3, 0 none
  output reg relay_energize, // Alarm relay drive
  output reg output_enable, // Load output allowed
  output reg output_reduce // Current limit reduces output
);

localparam NA = `ASA_N_ALM;

reg [`ASA_CTRL_W-1:0] ctrl;
reg [15:0] wd_ms;
reg [15:0] wd_cnt;
reg [31:0] ms_cnt;
reg wd_err;
reg [31:0] dwell_cnt;
reg [3:0] cur_idx;
reg cur_valid;
reg aw_got;
reg w_got;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg [NA-1:0] alm;
reg [3:0] next_idx;
reg next_valid;
reg [31:0] rd_val;
reg rd_ok;

wire [1:0] variant = ctrl[`ASA_F_VAR_HI:`ASA_F_VAR_LO];
wire is_third = (variant == `ASA_VAR_THIRD);
wire cl_fit = ctrl[`ASA_F_CL_FIT];
wire wd_en = ctrl[`ASA_F_WD_EN];
wire ph_alarm = is_third ? phase_lost[2] : (|phase_lost);
wire ph_side = is_third & (|phase_lost[1:0]);
wire stuck = ctrl[`ASA_F_SEL_STUCK] & switch_on_cont & (set_point < `ASA_STUCK_PCT);
wire ilim = cl_fit & cur_override;
wire ms_tick = (ms_cnt == MS_CYC - 1);
wire dwell_end = (dwell_cnt == DWELL_CYC - 1);
wire wr_go = aw_got & w_got & ~s_axi_bvalid;

// Finds the first active alarm after position cur, wrapping round, or from index 0 when from_top is set
function [4:0] pick_next;
  input [NA-1:0] vec;
  input [3:0] cur;
  input from_top;
  integer k;
  integer j;
  reg found;
  begin
    found = 1'b0;
    pick_next = 5'h00;
    for (k = 1; k <= NA; k = k + 1) begin
      j = from_top ? (k - 1) : ((cur + k) % NA);
      if (!found && vec[j]) begin
        found = 1'b1;
        pick_next = {1'b1, j[3:0]};
      end
    end
  end
endfunction

// Address to register value, flag set when mapped
function [32:0] reg_read;
  input [3:0] addr;
  input [`ASA_CTRL_W-1:0] c;
  input [15:0] t;
  input [NA-1:0] a;
  input [3:0] m;
  input [1:0] l;
  input r;
  input e;
  begin
    case (addr)
      `ASA_OFF_CTRL: reg_read = {1'b1, 24'h000000, c};
      `ASA_OFF_WDTO: reg_read = {1'b1, 16'h0000, t};
      `ASA_OFF_STAT: reg_read = {1'b1, 20'h00000, a};
      `ASA_OFF_DISP: reg_read = {1'b1, 24'h000000, e, r, l, m};
      default: reg_read = 33'h000000000;
    endcase
  end
endfunction

always @* begin
  alm = {NA{1'b0}};
  alm[`ASA_A_AUXHI] = aux_over;
  alm[`ASA_A_AUXLO] = aux_under;
  alm[`ASA_A_LINE] = elec_powered & (line_absent | ph_side);
  alm[`ASA_A_DRY] = drying_active;
  alm[`ASA_A_OPEN] = load_open;
  alm[`ASA_A_ILIM] = ilim;
  alm[`ASA_A_PHASE] = ph_alarm;
  alm[`ASA_A_CARD] = card_fault;
  alm[`ASA_A_STUCK] = stuck;
  alm[`ASA_A_OVHEAT] = overheat;
  alm[`ASA_A_UNBAL] = |leg_unbal;
  alm[`ASA_A_WDOG] = wd_err;
end

always @* begin
  {next_valid, next_idx} = pick_next(alm, cur_idx, ~cur_valid);
  {rd_ok, rd_val} = reg_read(s_axi_araddr, ctrl, wd_ms, alm, disp_msg,
    disp_leg, relay_energize, output_enable);
end

// Communication watchdog, counted in millisecond ticks
always @(posedge sys_clk) begin
  if (srst) begin
    ms_cnt <= 32'h00000000;
    wd_cnt <= 16'h0000;
    wd_err <= 1'b0;
  end else if (clk_en) begin
    if (!wd_en || comm_rx) begin
      ms_cnt <= 32'h00000000;
      wd_cnt <= 16'h0000;
      wd_err <= 1'b0;
    end else begin
      ms_cnt <= ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
      if (ms_tick && wd_cnt != wd_ms)
        wd_cnt <= wd_cnt + 16'h0001;
      if (wd_cnt == wd_ms)
        wd_err <= 1'b1;
    end
  end
end

// Message rotation over the active set
always @(posedge sys_clk) begin
  if (srst) begin
    cur_idx <= 4'h0;
    cur_valid <= 1'b0;
    dwell_cnt <= 32'h00000000;
  end else if (clk_en) begin
    if (!cur_valid || !alm[cur_idx] || dwell_end) begin
      cur_idx <= next_idx;
      cur_valid <= next_valid;
      dwell_cnt <= 32'h00000000;
    end else begin
      dwell_cnt <= dwell_cnt + 32'h00000001;
    end
  end
end

// Display, relay and output drives
always @(posedge sys_clk) begin
  if (srst) begin
    disp_msg <= `ASA_MSG_HOME;
    disp_flash <= 1'b0;
    disp_leg <= 2'h0;
    relay_energize <= 1'b0;
    output_enable <= 1'b0;
    output_reduce <= 1'b0;
  end else if (clk_en) begin
    if (cur_valid && alm[cur_idx]) begin
      disp_msg <= cur_idx + 4'h1;
      disp_flash <= 1'b1;
    end else begin
      disp_msg <= `ASA_MSG_HOME;
      disp_flash <= 1'b0;
    end
    if (leg_unbal[0])
      disp_leg <= 2'h1;
    else if (leg_unbal[1])
      disp_leg <= 2'h2;
    else if (leg_unbal[2])
      disp_leg <= 2'h3;
    else
      disp_leg <= 2'h0;
    relay_energize <= elec_powered & ~overheat
      & ~(ctrl[`ASA_F_SEL_OPEN] & load_open)
      & ~(ctrl[`ASA_F_SEL_ILIM] & ilim)
      & ~stuck
      & ~(ctrl[`ASA_F_SEL_WD] & wd_err);
    output_enable <= ~ph_alarm & ~overheat & ~wd_err;
    output_reduce <= ilim & (variant != `ASA_VAR_SECOND);
  end
end

// AXI4-Lite write path: address and data taken in either order
always @(posedge sys_clk) begin
  if (srst) begin
    aw_got <= 1'b0;
    w_got <= 1'b0;
    aw_addr <= 4'h0;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `ASA_RESP_OK;
    ctrl <= `ASA_CTRL_RST;
    wd_ms <= `ASA_WD_MS_RST;
  end else if (clk_en) begin
    s_axi_awready <= ~aw_got & ~(s_axi_awvalid & s_axi_awready);
    s_axi_wready <= ~w_got & ~(s_axi_wvalid & s_axi_wready);
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    if (wr_go) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `ASA_RESP_OK;
      case (aw_addr)
        `ASA_OFF_CTRL: begin
          if (w_strb[0])
            ctrl <= w_data[`ASA_CTRL_W-1:0];
        end
        `ASA_OFF_WDTO: begin
          if (w_strb[0])
            wd_ms[7:0] <= w_data[7:0];
          if (w_strb[1])
            wd_ms[15:8] <= w_data[15:8];
        end
        `ASA_OFF_STAT, `ASA_OFF_DISP: begin
          s_axi_bresp <= `ASA_RESP_OK;
        end
        default: begin
          s_axi_bresp <= `ASA_RESP_ERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

// AXI4-Lite read path
always @(posedge sys_clk) begin
  if (srst) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `ASA_RESP_OK;
  end else if (clk_en) begin
    s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
    if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `ASA_RESP_OK : `ASA_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

endmodule // asa_alarm_aggregator

// ### verif/asa_plant.sv
// Power stage model that presents fault and status lines
`timescale 1ns/1ps
module asa_plant (
  input wire sys_clk, // System clock
  input wire [14:0] fault, // Conditions to present
  output reg aux_over, // Aux supply high
  output reg aux_under, // Aux supply low
  output reg line_absent, // Line power gone
  output reg drying_active, // Drying in control
  output reg load_open, // Load resistance high
  output reg cur_override, // Current loop in control
  output reg card_fault, // Card failure
  output reg switch_on_cont, // Switch stuck on
  output reg overheat, // Heat sink hot
  output reg [2:0] phase_lost, // Lost phases
  output reg [2:0] leg_unbal // Unbalanced legs
);
  initial {leg_unbal, phase_lost, overheat, switch_on_cont, card_fault, cur_override, load_open,
    drying_active, line_absent, aux_under, aux_over} = 15'h0;
  // Sensed conditions reach the controller one clock after they occur
  always @(posedge sys_clk) begin
    {leg_unbal, phase_lost, overheat, switch_on_cont, card_fault, cur_override, load_open,
      drying_active, line_absent, aux_under, aux_over} <= fault;
  end
endmodule // asa_plant

// ### verif/asa_alarm_aggregator_sva.sv
// Port checker for the alarm aggregator
`timescale 1ns/1ps
module asa_checker (
  input wire sys_clk, // Clock
  input wire srst, // Reset
  input wire clk_en, // Run enable
  input wire elec_powered, // Supply present
  input wire overheat, // Heat sink hot
  input wire [2:0] phase_lost, // Lost phases
  input wire s_axi_arvalid, // Read request
  input wire s_axi_arready, // Read accept
  input wire s_axi_rvalid, // Read answer
  input wire [3:0] disp_msg, // Message code
  input wire disp_flash, // Flashing
  input wire relay_energize, // Relay drive
  input wire output_enable // Load allowed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence heat_held;
    clk_en && overheat ##1 clk_en && overheat;
  endsequence
  chk_heat_relay: assert property (clk_en && overheat |=> !relay_energize)
    else $error("relay energized under overheat");
  chk_heat_off: assert property (clk_en && overheat |=> !output_enable)
    else $error("load enabled under overheat");
  chk_phase_off: assert property (clk_en && phase_lost[2] |=> !output_enable)
    else $error("load enabled with phase three lost");
  chk_relay_power: assert property (clk_en && !elec_powered |=> !relay_energize)
    else $error("relay energized without supply");
  chk_flash_code: assert property (disp_flash == (disp_msg != 4'h0))
    else $error("flash and message code disagree");
  chk_heat_shown: assert property (heat_held |=> disp_flash)
    else $error("no message for overheat");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read not answered");
  chk_reset_quiet: assert property ($fell(srst) |-> !relay_energize && !output_enable)
    else $error("outputs active at reset release");
endmodule // asa_checker
bind asa_alarm_aggregator asa_checker i_asa_checker (.*);

// ### verif/tb_alarm_status_aggregator.sv
// Self-checking bench for the alarm aggregator
`timescale 1ns/1ps
`include "asa_map.vh"
module tb_alarm_status_aggregator;
  logic sys_clk = 1'h0, srst = 1'h1, clk_en = 1'h1, elec_powered = 1'h1, comm_rx = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, rd_d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s1, s8;
  logic [6:0] set_point = 7'h32;
  logic [14:0] fault = 15'h0;
  logic [1:0] rd_r, wr_b;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, disp_leg;
  wire [31:0] s_axi_rdata;
  wire [3:0] disp_msg;
  wire disp_flash, relay_energize, output_enable, output_reduce, aux_over, aux_under;
  wire line_absent, drying_active, load_open, cur_override, card_fault, switch_on_cont, overheat;
  wire [2:0] phase_lost, leg_unbal;
  int error_cnt = 0, comparisons = 0, i, n;
  // Control, fault lines, then expected {msg, leg, relay, enable, reduce}
  logic [31:0] rows [18] = '{
    {8'h00, 15'h0000, 9'h006},
    {8'h00, 15'h0001, 9'h146},
    {8'h00, 15'h0002, 9'h166},
    {8'h00, 15'h0004, 9'h126},
    {8'h00, 15'h0008, 9'h186},
    {8'h00, 15'h0010, 9'h0c6},
    {8'h04, 15'h0010, 9'h0c2},
    {8'h80, 15'h0020, 9'h0a7},
    {8'h89, 15'h0020, 9'h0a2},
    {8'h82, 15'h0020, 9'h0a7},
    {8'h00, 15'h0040, 9'h106},
    {8'h10, 15'h0080, 9'h082},
    {8'h00, 15'h0080, 9'h006},
    {8'h00, 15'h0100, 9'h020},
    {8'h00, 15'h0200, 9'h044},
    {8'h02, 15'h0200, 9'h126},
    {8'h02, 15'h0800, 9'h044},
    {8'h00, 15'h2000, 9'h0f6}};
  always #10 sys_clk = ~sys_clk;
  asa_alarm_aggregator #(.DWELL_CYC(8), .MS_CYC(4)) i_asa_alarm_aggregator (.*);
  asa_plant i_asa_plant (.*);
  task summarize;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    if (n >= 40) begin
      error_cnt++;
      $display("BAD %0t bus wait ran out", $time);
      summarize;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    wr_b = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tmo;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tmo;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    cmp({relay_energize, output_enable}, 32'h0);
    srst <= 1'h0;
    rd(`ASA_OFF_WDTO);
    cmp(rd_d, `ASA_WD_MS_RST);
    for (i = 0; i < 18; i++) begin
      wr(`ASA_OFF_CTRL, rows[i][31:24]);
      fault <= rows[i][23:9];
      repeat (6) @(posedge sys_clk);
      cmp({disp_msg, disp_leg, relay_energize, output_enable, output_reduce}, rows[i][8:0]);
    end
    wr(`ASA_OFF_CTRL, 32'h0);
    fault <= 15'h0140;
    s1 = 1'h0;
    s8 = 1'h0;
    repeat (40) begin
      @(posedge sys_clk);
      s1 |= disp_msg === 4'h1;
      s8 |= disp_msg === 4'h8;
    end
    cmp({s1, s8}, 32'h3);
    cmp(disp_flash, 32'h1);
    fault <= 15'h0080;
    set_point <= 7'h5a;
    wr(`ASA_OFF_CTRL, 32'h10);
    repeat (6) @(posedge sys_clk);
    cmp(relay_energize, 32'h1);
    fault <= 15'h0;
    elec_powered <= 1'h0;
    repeat (4) @(posedge sys_clk);
    cmp(relay_energize, 32'h0);
    elec_powered <= 1'h1;
    wr(`ASA_OFF_WDTO, 32'h2);
    cmp(wr_b, `ASA_RESP_OK);
    wr(`ASA_OFF_CTRL, 32'h60);
    repeat (30) @(posedge sys_clk);
    cmp({relay_energize, output_enable}, 32'h0);
    comm_rx <= 1'h1;
    @(posedge sys_clk);
    comm_rx <= 1'h0;
    repeat (3) @(posedge sys_clk);
    cmp(output_enable, 32'h1);
    // Clock enable low must freeze the outputs
    clk_en <= 1'h0;
    fault <= 15'h0100;
    repeat (4) @(posedge sys_clk);
    cmp(output_enable, 32'h1);
    clk_en <= 1'h1;
    repeat (4) @(posedge sys_clk);
    cmp(output_enable, 32'h0);
    fault <= 15'h0;
    wr(4'h2, 32'h0);
    cmp(wr_b, `ASA_RESP_ERR);
    rd(`ASA_OFF_WDTO);
    cmp(rd_d, 32'h2);
    rd(4'h2);
    cmp(rd_r, `ASA_RESP_ERR);
    summarize;
  end
endmodule // tb_alarm_status_aggregator
